// ===== hw/ibag_defs.vh
`ifndef IBAG_DEFS_VH
`define IBAG_DEFS_VH

// register offsets, byte addresses
`define IBAG_OFF_REMAP       8'h00
`define IBAG_OFF_ABT_STATUS  8'h04
`define IBAG_OFF_ABT_ADDR    8'h08
`define IBAG_OFF_REGION0     8'h10
`define IBAG_OFF_REGION15    8'h4c
`define IBAG_OFF_PERIPH      8'h50
`define IBAG_OFF_PERIPHERAL_PROTECTION_FIELD_EN     8'h54

// remap control register
`define IBAG_REMAP_TOGGLE_BIT 0

// abort status register fields
`define IBAG_ASR_UNDEF_BIT   0
`define IBAG_ASR_MISAL_BIT   1
`define IBAG_ASR_PERIPHERAL_PROTECTION_FIELD_BIT    2
`define IBAG_ASR_SIZE_LSB    8
`define IBAG_ASR_TYPE_LSB    10
`define IBAG_ASR_SRC_DMA     16
`define IBAG_ASR_SRC_CPU     17
`define IBAG_ASR_STK_DMA     24
`define IBAG_ASR_STK_CPU     25

// region register fields: access code, size code, base address bits 27:10
`define IBAG_RGN_AP_LSB      0
`define IBAG_RGN_SIZE_LSB    4
`define IBAG_RGN_BASE_LSB    10
`define IBAG_RGN_RESET       32'h0000_0000
`define IBAG_RGN_SIZE_MAX    4'hc
`define IBAG_NUM_REGIONS     16

// access codes: none, privileged rw, privileged rw + user read, full
`define IBAG_AP_NONE         2'h0
`define IBAG_AP_PRIV         2'h1
`define IBAG_AP_USER_RD      2'h2
`define IBAG_AP_FULL         2'h3

// access size and type encodings
`define IBAG_SZ_BYTE         2'h0
`define IBAG_SZ_HALF         2'h1
`define IBAG_SZ_WORD         2'h2
`define IBAG_TYP_READ        2'h0
`define IBAG_TYP_WRITE       2'h1
`define IBAG_TYP_FETCH       2'h2

// top nibble decode areas
`define IBAG_AREA_INTERNAL   4'h0
`define IBAG_AREA_EXT_FIRST  4'h1
`define IBAG_AREA_EXT_LAST   4'h8
`define IBAG_AREA_PERIPH     4'hf

// 1 MB blocks inside the internal area
`define IBAG_BLK_AREA0       8'h00
`define IBAG_BLK_FLASH       8'h01
`define IBAG_BLK_SRAM        8'h02
`define IBAG_BLK_ROM         8'h03

// target select codes
`define IBAG_TGT_NONE        3'h0
`define IBAG_TGT_ROM         3'h1
`define IBAG_TGT_FLASH       3'h2
`define IBAG_TGT_SRAM        3'h3
`define IBAG_TGT_EXT         3'h4
`define IBAG_TGT_PERIPH      3'h5

`endif

// ===== hw/ibag_guard.v
// Contract
// [RQ1] area zero holds the vector table
// [RQ2] area zero boots rom or flash
// [RQ3] full erase clears boot select bit
// [RQ4] remap aliases sram into area zero
// [RQ5] writing one toggles remap, zero ignored
// [RQ6] abort on undefined, protected or misaligned
// [RQ7] abort goes to every master
// [RQ8] only the cpu acts on abort
// [RQ9] capture full abort address
// [RQ10] record size, type and cause
// [RQ11] source bits and sticky per master
// [RQ12] sixteen regions, internal memory only
// [RQ13] protection off until enable written
// [RQ14] region size power of two 1K-4M
// [RQ15] peripheral space has own protection field
// [RQ16] forbidden write or user access aborts
// [RQ17] overlapping regions use most restrictive
// [RQ18] address outside all regions aborts
// [RQ19] region reset zero blocks first 1K
// [RQ20] software opens first 4M at init
// [RQ21] misaligned word or half aborts
// [RQ22] cpu instruction fetch skips alignment
//
// Our own choices: the address map and the address-and-strobe port.

`timescale 1ns/1ns
`include "ibag_defs.vh"

module ibag_guard (
    input  wire        clk_sys_i,
    input  wire        resetn_i,
    input  wire [7:0]  reg_addr_i,
    input  wire [31:0] reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [31:0] reg_rdata_o,
    input  wire        acc_valid_i,
    input  wire [31:0] acc_addr_i,
    input  wire [1:0]  acc_size_i,
    input  wire [1:0]  acc_type_i,
    input  wire        acc_cpu_i,
    input  wire        acc_priv_i,
    input  wire        nvm_boot_set_i,
    input  wire        full_erase_i,
    output reg         fwd_valid_o,
    output reg  [2:0]  fwd_target_o,
    output reg  [31:0] fwd_addr_o,
    output reg         abort_o,
    output reg         remap_o,
    output reg         boot_flash_o,
    output reg         peripheral_protection_field_en_o
);

    // register state
    reg        remap_r;
    reg        boot_nvm_r;
    reg        peripheral_protection_field_en_r;
    reg [1:0]  periph_ap_r;
    reg [31:0] region_r [0:`IBAG_NUM_REGIONS-1];

    // abort capture state, kept until the next abort; the sticky bits also clear on a status read
    reg [31:0] abt_addr_r;
    reg        undef_r;
    reg        misal_r;
    reg        protv_r;
    reg [1:0]  abt_size_r;
    reg [1:0]  abt_type_r;
    reg        src_dma_r;
    reg        src_cpu_r;
    reg        stk_dma_r;
    reg        stk_cpu_r;

    // permission check shared by regions and peripheral space
    // fetches count as reads here
    function perm_ok;
        input [1:0] ap;
        input       priv;
        input       wr;
        begin
            // user-read code: privileged rw, user read only
            case (ap)
                `IBAG_AP_NONE:    perm_ok = 1'b0;
                `IBAG_AP_PRIV:    perm_ok = priv;
                `IBAG_AP_USER_RD: perm_ok = priv | ~wr;
                `IBAG_AP_FULL:    perm_ok = 1'b1;
                default:          perm_ok = 1'b0;
            endcase
        end
    endfunction

    // region hit: base bits below the region size are ignored
    function rgn_hit;
        input [31:0] rgn;
        input [27:0] addr;
        reg   [3:0]  sz;
        reg   [17:0] mask;
        begin
            sz = rgn[`IBAG_RGN_SIZE_LSB +: 4];
            // clamp stray codes to the 4M maximum
            if (sz > `IBAG_RGN_SIZE_MAX) begin
                sz = `IBAG_RGN_SIZE_MAX;
            end
            // keep only base bits above the size
            mask = 18'h3ffff << sz;                                   // [RQ14]
            rgn_hit = ((addr[27:10] ^ rgn[`IBAG_RGN_BASE_LSB +: 18]) & mask) == 18'h00000;
        end
    endfunction

    // address decode of the incoming access
    wire [3:0] area     = acc_addr_i[31:28];
    wire [7:0] blk      = acc_addr_i[27:20];
    wire       is_int   = (area == `IBAG_AREA_INTERNAL);
    wire       is_ext   = (area >= `IBAG_AREA_EXT_FIRST) && (area <= `IBAG_AREA_EXT_LAST);
    wire       is_per   = (area == `IBAG_AREA_PERIPH);
    wire       is_wr    = (acc_type_i == `IBAG_TYP_WRITE);

    // internal block decode; area zero follows the remap and boot bits
    // blocks above rom are unpopulated
    reg  [2:0] int_tgt;
    always @* begin
        case (blk)
            `IBAG_BLK_AREA0: begin
                if (remap_r) begin
                    int_tgt = `IBAG_TGT_SRAM;                         // [RQ4]
                end else if (boot_nvm_r) begin
                    int_tgt = `IBAG_TGT_FLASH;                        // [RQ2]
                end else begin
                    int_tgt = `IBAG_TGT_ROM;                          // [RQ2]
                end
            end
            `IBAG_BLK_FLASH: int_tgt = `IBAG_TGT_FLASH;
            `IBAG_BLK_SRAM:  int_tgt = `IBAG_TGT_SRAM;
            `IBAG_BLK_ROM:   int_tgt = `IBAG_TGT_ROM;
            default:         int_tgt = `IBAG_TGT_NONE;
        endcase
    end

    // physical address: area zero reaches the mapped memory's own block,
    // so the vector table at the bottom 32 bytes is that memory's start
    // unmapped blocks pass their own number through
    reg  [7:0] phys_blk;
    always @* begin
        case (int_tgt)
            `IBAG_TGT_FLASH: phys_blk = `IBAG_BLK_FLASH;
            `IBAG_TGT_SRAM:  phys_blk = `IBAG_BLK_SRAM;
            `IBAG_TGT_ROM:   phys_blk = `IBAG_BLK_ROM;
            default:         phys_blk = blk;
        endcase
    end
    wire [31:0] int_phys = {area, phys_blk, acc_addr_i[19:0]};      // [RQ1]

    // per-region hit and permission, one instance per region
    // all regions compare at once, one-cycle answer
    wire [`IBAG_NUM_REGIONS-1:0] hit_vec;
    wire [`IBAG_NUM_REGIONS-1:0] deny_vec;
    genvar gi;
    generate
        for (gi = 0; gi < `IBAG_NUM_REGIONS; gi = gi + 1) begin : g_rgn
            assign hit_vec[gi]  = rgn_hit(region_r[gi], acc_addr_i[27:0]);
            assign deny_vec[gi] = hit_vec[gi] &
                ~perm_ok(region_r[gi][`IBAG_RGN_AP_LSB +: 2], acc_priv_i, is_wr);
        end
    endgenerate

    // any denying hit wins, so overlap gives the strongest protection;
    // external areas are never checked
    // reset regions deny 1K at zero until opened
    // the peripheral field guards the whole top area
    wire rgn_viol = is_int & ((|deny_vec) | ~(|hit_vec));         // [RQ12] [RQ17] [RQ18]
    wire per_viol = is_per & ~perm_ok(periph_ap_r, acc_priv_i, is_wr);   // [RQ15]
    wire peripheral_protection_field_viol = peripheral_protection_field_en_r & (rgn_viol | per_viol);            // [RQ13] [RQ16]

    // alignment check; cpu fetches are exempt
    // dma fetches stay checked
    wire is_fetch_cpu = acc_cpu_i & (acc_type_i == `IBAG_TYP_FETCH);  // [RQ22]
    wire bad_align =
        ((acc_size_i == `IBAG_SZ_WORD) & (acc_addr_i[1:0] != 2'h0)) |
        ((acc_size_i == `IBAG_SZ_HALF) & acc_addr_i[0]);            // [RQ21]
    wire misal = bad_align & ~is_fetch_cpu;

    // undefined: reserved top areas or unpopulated internal blocks
    // no target exists, so nothing else applies
    wire undef = ~(is_ext | is_per) & ~(is_int & (int_tgt != `IBAG_TGT_NONE));

    // single cause by priority: undefined, misaligned, protection
    // one flag per abort, never two
    wire c_undef = undef;
    wire c_misal = ~undef & misal;
    wire c_peripheral_protection_field  = ~undef & ~misal & peripheral_protection_field_viol;
    wire abort   = acc_valid_i & (c_undef | c_misal | c_peripheral_protection_field);    // [RQ6]

    // target of a good access
    // driven even when aborted; valid qualifies them
    reg  [2:0]  tgt;
    reg  [31:0] phys;
    always @* begin
        if (is_int) begin
            tgt  = int_tgt;
            phys = int_phys;
        end else if (is_ext) begin
            tgt  = `IBAG_TGT_EXT;
            phys = acc_addr_i;
        end else if (is_per) begin
            tgt  = `IBAG_TGT_PERIPH;
            phys = acc_addr_i;
        end else begin
            tgt  = `IBAG_TGT_NONE;
            phys = acc_addr_i;
        end
    end

    // register decode
    // word offsets of the window only
    wire wr_remap = reg_wr_i & (reg_addr_i == `IBAG_OFF_REMAP);
    wire wr_per   = reg_wr_i & (reg_addr_i == `IBAG_OFF_PERIPH);
    wire wr_en    = reg_wr_i & (reg_addr_i == `IBAG_OFF_PERIPHERAL_PROTECTION_FIELD_EN);
    wire rd_asr   = reg_rd_i & (reg_addr_i == `IBAG_OFF_ABT_STATUS);
    wire in_rgn   = (reg_addr_i >= `IBAG_OFF_REGION0) &&
                    (reg_addr_i <= `IBAG_OFF_REGION15) && (reg_addr_i[1:0] == 2'h0);
    // 0x10 is region 0; 0x4c wraps to region 15
    wire [3:0] rgn_idx = reg_addr_i[5:2] - 4'h4;

    // access outcome, registered toward the masters
    // target and address move every cycle
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            fwd_valid_o  <= 1'b0;
            fwd_target_o <= `IBAG_TGT_NONE;
            fwd_addr_o   <= 32'h0000_0000;
            abort_o      <= 1'b0;
        end else begin
            fwd_valid_o  <= acc_valid_i & ~abort;                  // aborted access is cancelled
            fwd_target_o <= tgt;
            fwd_addr_o   <= phys;
            abort_o      <= abort;                                 // [RQ7] one line to all masters
        end
    end

    // remap toggle, protection enable and peripheral access code
    // remap reads back only through remap_o
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            remap_r     <= 1'b0;                                   // [RQ5]
            peripheral_protection_field_en_r   <= 1'b0;                                   // [RQ13]
            periph_ap_r <= `IBAG_AP_NONE;
        end else begin
            if (wr_remap && reg_wdata_i[`IBAG_REMAP_TOGGLE_BIT]) begin
                remap_r <= ~remap_r;                               // [RQ5]
            end
            // writing zero turns protection off again
            if (wr_en) begin
                peripheral_protection_field_en_r <= reg_wdata_i[0];                       // [RQ13]
            end
            if (wr_per) begin
                periph_ap_r <= reg_wdata_i[1:0];                   // [RQ15]
            end
        end
    end

    // boot select bit: erase wins over a set in the same cycle
    // so an erase always ends with rom boot
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            boot_nvm_r <= 1'b0;
        end else if (full_erase_i) begin
            boot_nvm_r <= 1'b0;                                    // [RQ3]
        end else if (nvm_boot_set_i) begin
            boot_nvm_r <= 1'b1;
        end
    end

    // region registers, all reset to zero
    // one write port, indexed by the offset
    integer ri;
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            // each starts as a closed 1K block at zero
            for (ri = 0; ri < `IBAG_NUM_REGIONS; ri = ri + 1) begin
                region_r[ri] <= `IBAG_RGN_RESET;                   // [RQ19]
            end
        end else if (reg_wr_i && in_rgn) begin
            region_r[rgn_idx] <= reg_wdata_i;
        end
    end

    // abort capture; a new abort wins over a status read in the same cycle
    // the address is stored as presented, remap not applied
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            abt_addr_r <= 32'h0000_0000;
            undef_r    <= 1'b0;
            misal_r    <= 1'b0;
            protv_r    <= 1'b0;
            abt_size_r <= `IBAG_SZ_BYTE;
            abt_type_r <= `IBAG_TYP_READ;
            src_dma_r  <= 1'b0;
            src_cpu_r  <= 1'b0;
            stk_dma_r  <= 1'b0;
            stk_cpu_r  <= 1'b0;
        end else begin
            // status read clears both sticky bits
            if (rd_asr) begin
                stk_dma_r <= 1'b0;
                stk_cpu_r <= 1'b0;
            end
            // all fields together, so they always match
            if (abort) begin
                abt_addr_r <= acc_addr_i;                          // [RQ9]
                undef_r    <= c_undef;                             // [RQ10]
                misal_r    <= c_misal;
                protv_r    <= c_peripheral_protection_field;
                abt_size_r <= acc_size_i;
                abt_type_r <= acc_type_i;
                src_dma_r  <= ~acc_cpu_i;                          // [RQ11]
                src_cpu_r  <= acc_cpu_i;
                if (acc_cpu_i) begin
                    stk_cpu_r <= 1'b1;                             // [RQ11]
                end else begin
                    stk_dma_r <= 1'b1;
                end
            end
        end
    end

    // status word assembly
    // unused bits read as zero
    wire [31:0] asr_word =
        ({31'h0, undef_r}    << `IBAG_ASR_UNDEF_BIT) |
        ({31'h0, misal_r}    << `IBAG_ASR_MISAL_BIT) |
        ({31'h0, protv_r}    << `IBAG_ASR_PERIPHERAL_PROTECTION_FIELD_BIT)  |
        ({30'h0, abt_size_r} << `IBAG_ASR_SIZE_LSB)  |
        ({30'h0, abt_type_r} << `IBAG_ASR_TYPE_LSB)  |
        ({31'h0, src_dma_r}  << `IBAG_ASR_SRC_DMA)   |
        ({31'h0, src_cpu_r}  << `IBAG_ASR_SRC_CPU)   |
        ({31'h0, stk_dma_r}  << `IBAG_ASR_STK_DMA)   |
        ({31'h0, stk_cpu_r}  << `IBAG_ASR_STK_CPU);

    // read mux; remap register is write-only and unmapped reads give zero
    // regions read back exactly as written
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h0000_0000;
        if (in_rgn) begin
            rd_mux = region_r[rgn_idx];
        end else begin
            case (reg_addr_i)
                `IBAG_OFF_ABT_STATUS: rd_mux = asr_word;
                `IBAG_OFF_ABT_ADDR:   rd_mux = abt_addr_r;
                `IBAG_OFF_PERIPH:     rd_mux = {30'h0, periph_ap_r};
                `IBAG_OFF_PERIPHERAL_PROTECTION_FIELD_EN:    rd_mux = {31'h0, peripheral_protection_field_en_r};
                default:              rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // read data and state mirrors, all from flops
    // mirrors lag the internal state by one cycle
    always @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            reg_rdata_o  <= 32'h0000_0000;
            remap_o      <= 1'b0;
            boot_flash_o <= 1'b0;
            peripheral_protection_field_en_o    <= 1'b0;
        end else begin
            // zero except in the cycle after a read
            reg_rdata_o  <= reg_rd_i ? rd_mux : 32'h0000_0000;
            remap_o      <= remap_r;
            boot_flash_o <= boot_nvm_r;
            peripheral_protection_field_en_o    <= peripheral_protection_field_en_r;
        end
    end

endmodule

// ===== testbench/ibag_guard_checker.sv
`timescale 1ns/1ns
`include "ibag_defs.vh"
module ibag_guard_checker (
    input wire        clk_sys_i,
    input wire        resetn_i,
    input wire [7:0]  reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire        reg_wr_i,
    input wire        acc_valid_i,
    input wire [31:0] acc_addr_i,
    input wire [1:0]  acc_size_i,
    input wire [1:0]  acc_type_i,
    input wire        acc_cpu_i,
    input wire        full_erase_i,
    input wire        fwd_valid_o,
    input wire [2:0]  fwd_target_o,
    input wire [31:0] fwd_addr_o,
    input wire        abort_o,
    input wire        remap_o,
    input wire        boot_flash_o,
    input wire        peripheral_protection_field_en_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    // decoded strobes; toggles on adjacent cycles are skipped, they cancel
    wire tog_w   = reg_wr_i && reg_addr_i == `IBAG_OFF_REMAP && reg_wdata_i[0];
    wire pen_w   = reg_wr_i && reg_addr_i == `IBAG_OFF_PERIPHERAL_PROTECTION_FIELD_EN && reg_wdata_i[0];
    wire fetch_w = acc_cpu_i && acc_type_i == `IBAG_TYP_FETCH;
    reg  tog_d_r;
    always @(posedge clk_sys_i) begin
        tog_d_r <= tog_w;
    end
    chk_one_answer: assert property (acc_valid_i |=> fwd_valid_o != abort_o)
        else $error("access not answered by exactly one of forward or abort");
    chk_no_answer: assert property (!acc_valid_i |=> !fwd_valid_o && !abort_o)
        else $error("answer without an access");
    chk_undef_abort: assert property (acc_valid_i && acc_addr_i[31:28] >= 4'h9
        && acc_addr_i[31:28] <= 4'he |=> abort_o) else $error("undefined area not aborted");
    chk_misal_word: assert property (acc_valid_i && acc_size_i == `IBAG_SZ_WORD
        && acc_addr_i[1:0] != 2'h0 && !fetch_w |=> abort_o)
        else $error("misaligned word not aborted");
    chk_fetch_free: assert property (acc_valid_i && fetch_w && acc_addr_i[31:28] == 4'h1
        |=> fwd_valid_o && fwd_target_o == `IBAG_TGT_EXT) else $error("cpu fetch was checked");
    chk_area_zero: assert property (acc_valid_i && acc_addr_i[31:20] == 12'h000
        |=> !fwd_valid_o || fwd_addr_o == {4'h0, (remap_o ? `IBAG_BLK_SRAM : boot_flash_o ?
        `IBAG_BLK_FLASH : `IBAG_BLK_ROM), $past(acc_addr_i[19:0])} && fwd_target_o ==
        (remap_o ? `IBAG_TGT_SRAM : boot_flash_o ? `IBAG_TGT_FLASH : `IBAG_TGT_ROM))
        else $error("area zero mapped to wrong block");
    chk_remap_flip: assert property (tog_w && !tog_d_r |->
        ##2 remap_o != $past(remap_o, 2)) else $error("remap did not toggle");
    chk_erase_boot: assert property (full_erase_i |-> ##2 !boot_flash_o)
        else $error("erase left flash boot selected");
    chk_peripheral_protection_field_cause: assert property ($rose(peripheral_protection_field_en_o) |-> $past(pen_w, 2))
        else $error("protection enabled without a write");
    cover property (abort_o && $past(acc_cpu_i));
    cover property ($rose(remap_o));
    cover property (fwd_valid_o && fwd_target_o == `IBAG_TGT_PERIPH && peripheral_protection_field_en_o);
endmodule
bind ibag_guard ibag_guard_checker chk_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .acc_valid_i(acc_valid_i), .acc_addr_i(acc_addr_i), .acc_size_i(acc_size_i),
    .acc_type_i(acc_type_i), .acc_cpu_i(acc_cpu_i), .full_erase_i(full_erase_i),
    .fwd_valid_o(fwd_valid_o), .fwd_target_o(fwd_target_o), .fwd_addr_o(fwd_addr_o),
    .abort_o(abort_o), .remap_o(remap_o), .boot_flash_o(boot_flash_o), .peripheral_protection_field_en_o(peripheral_protection_field_en_o));

// ===== testbench/ibag_bus_masters.sv
`timescale 1ns/1ns
module ibag_bus_masters (
    input  wire        clk_sys_i,
    input  wire        abort_i,
    output reg         acc_valid_o  = 1'b0,
    output reg  [31:0] acc_addr_o   = 32'h0000_0000,
    output reg  [1:0]  acc_size_o   = 2'h0,
    output reg  [1:0]  acc_type_o   = 2'h0,
    output reg         acc_cpu_o    = 1'b0,
    output reg         acc_priv_o   = 1'b0,
    output reg  [7:0]  cpu_aborts_o = 8'h00
);
    // each variable has one writer: the task or the counter process
    reg cpu_busy_r = 1'b0;
    // one access per call; released address shows the inverted address, not the old value
    task issue(input [31:0] a, input [1:0] s, t, input c, p);
        @(posedge clk_sys_i);
        {acc_valid_o, acc_addr_o, acc_size_o, acc_type_o, acc_cpu_o, acc_priv_o} <=
            {1'b1, a, s, t, c, p};
        @(posedge clk_sys_i);
        {acc_valid_o, acc_addr_o} <= {1'b0, ~a};
    endtask
    // the dma side ignores abort; the cpu counts it only for its own access
    always @(posedge clk_sys_i) begin
        cpu_busy_r <= acc_valid_o && acc_cpu_o;
        if (abort_i && cpu_busy_r) begin
            cpu_aborts_o <= cpu_aborts_o + 8'h1;
        end
    end
endmodule

// ===== testbench/internal_bus_access_guard_remap_tb.sv
`timescale 1ns/1ns
`include "ibag_defs.vh"
module internal_bus_access_guard_remap_tb;
    localparam [1:0] sz_b = `IBAG_SZ_BYTE, sz_h = `IBAG_SZ_HALF, sz_w = `IBAG_SZ_WORD;
    localparam [1:0] ty_r = `IBAG_TYP_READ, ty_w = `IBAG_TYP_WRITE, ty_f = `IBAG_TYP_FETCH;
    localparam [3:0] t_rom = 4'h1, t_flash = 4'h2, t_sram = 4'h3, t_ext = 4'h4, t_per = 4'h5;
    localparam [3:0] ab = 4'h8;
    reg         clk_sys_i, resetn_i, wr_s, rd_s, nvm_set, erase, rd_d;
    reg  [7:0]  addr;
    reg  [31:0] wdata, seed, a;
    wire [31:0] rdata, f_addr, a_addr;
    wire [2:0]  tgt;
    wire [1:0]  a_size, a_type;
    wire        fwd, abt, a_val, a_cpu, a_priv;
    wire [7:0]  cpu_abts;
    integer     fails, n_checks, i, n_cpu;
    reg  [31:0] q_rd[$];
    reg  [3:0]  q_acc[$];

    ibag_guard dut_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
        .acc_valid_i(a_val), .acc_addr_i(a_addr), .acc_size_i(a_size), .acc_type_i(a_type),
        .acc_cpu_i(a_cpu), .acc_priv_i(a_priv), .nvm_boot_set_i(nvm_set),
        .full_erase_i(erase), .fwd_valid_o(fwd), .fwd_target_o(tgt), .fwd_addr_o(f_addr),
        .abort_o(abt), .remap_o(), .boot_flash_o(), .peripheral_protection_field_en_o());
    ibag_bus_masters m_u (.clk_sys_i(clk_sys_i), .abort_i(abt), .acc_valid_o(a_val),
        .acc_addr_o(a_addr), .acc_size_o(a_size), .acc_type_o(a_type), .acc_cpu_o(a_cpu),
        .acc_priv_o(a_priv), .cpu_aborts_o(cpu_abts));

    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    function [31:0] lfsr(input [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // status word: cause flag, size, type, source and sticky of the master
    function [31:0] st(input [1:0] cause, s, t, input c);
        st = (32'h1 << cause) | {s, 8'h0} | {t, 10'h0} | (c ? 32'h0202_0000 : 32'h0101_0000);
    endfunction
    task check(input [31:0] seen, input [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task wr(input [7:0] ad, input [31:0] d);
        @(posedge clk_sys_i);
        {wr_s, addr, wdata} <= {1'b1, ad, d};
        @(posedge clk_sys_i);
        wr_s <= 1'b0;
    endtask
    task rd(input [7:0] ad, input [31:0] e);
        q_rd.push_back(e);
        @(posedge clk_sys_i);
        {rd_s, addr} <= {1'b1, ad};
        @(posedge clk_sys_i);
        rd_s <= 1'b0;
    endtask
    task acc(input [31:0] ad, input [1:0] s, t, input c, p, input [3:0] e);
        q_acc.push_back(e);
        m_u.issue(ad, s, t, c, p);
    endtask
    // aborted access, then abort address and status read back
    task tryab(input [31:0] ad, input [1:0] s, t, input c, p, input [1:0] cause);
        acc(ad, s, t, c, p, ab);
        rd(8'h08, ad);
        rd(8'h04, st(cause, s, t, c));
        n_cpu = n_cpu + c;
    endtask
    // results are matched against the oldest notes once they have settled
    always @(posedge clk_sys_i) rd_d <= rd_s;
    always @(negedge clk_sys_i) begin
        if (rd_d) check(rdata, q_rd.pop_front());
        if (fwd || abt) check({abt, abt ? 3'h0 : tgt}, q_acc.pop_front());
    end
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        fails = fails + 1;
        wrap_up;
    end
    initial begin
        {resetn_i, wr_s, rd_s, nvm_set, erase, addr, wdata} = 0;
        fails = 0;
        n_checks = 0;
        n_cpu = 0;
        seed = 32'hca6e147e;
        repeat (4) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        for (i = 0; i < 'h5c; i = i + 4) rd(i[7:0], 32'h0);
        $display("test reset values done");
        acc(32'h0, sz_w, ty_r, 1, 1, t_rom);
        @(posedge clk_sys_i) nvm_set <= 1'b1;
        @(posedge clk_sys_i) nvm_set <= 1'b0;
        acc(32'h4, sz_w, ty_f, 1, 1, t_flash);
        @(posedge clk_sys_i) erase <= 1'b1;
        @(posedge clk_sys_i) erase <= 1'b0;
        acc(32'h1c, sz_w, ty_r, 0, 1, t_rom);
        wr(8'h00, 32'h1);
        acc(32'h0, sz_w, ty_r, 1, 1, t_sram);
        acc(32'h0020_0000, sz_w, ty_r, 1, 1, t_sram);
        wr(8'h00, 32'hffff_fffe);
        acc(32'h8, sz_h, ty_w, 1, 1, t_sram);
        wr(8'h00, 32'h1);
        acc(32'h0, sz_b, ty_r, 1, 1, t_rom);
        $display("test boot and remap done");
        // random addresses in every undefined area, either master
        for (i = 0; i < 6; i = i + 1) begin
            seed = lfsr(seed);
            a = {4'h9 + i[3:0], seed[27:2], 2'h0};
            tryab(a, sz_w, ty_w, seed[0], 1, 0);
        end
        tryab(32'h0040_0000, sz_w, ty_r, 1, 1, 0);
        tryab(32'h9000_0001, sz_w, ty_r, 0, 1, 0);
        tryab(32'h0020_0002, sz_w, ty_r, 0, 1, 1);
        tryab(32'h0020_0001, sz_w, ty_w, 1, 1, 1);
        tryab(32'h0020_0003, sz_h, ty_r, 1, 1, 1);
        tryab(32'h1000_0002, sz_w, ty_f, 0, 1, 1);
        acc(32'h1000_0002, sz_w, ty_f, 1, 1, t_ext);
        acc(32'h0020_0002, sz_h, ty_w, 0, 1, t_sram);
        acc(32'h0030_0003, sz_b, ty_w, 1, 1, t_rom);
        acc(32'h0010_0000, sz_w, ty_r, 0, 1, t_flash);
        acc(32'hf000_0000, sz_w, ty_r, 0, 0, t_per);
        acc(32'ha000_0000, sz_b, ty_r, 0, 1, ab);
        acc(32'hb000_0000, sz_b, ty_r, 1, 1, ab);
        n_cpu = n_cpu + 1;
        rd(8'h04, st(0, sz_b, ty_r, 1) | 32'h0100_0000);
        rd(8'h04, st(0, sz_b, ty_r, 1) & 32'hfcff_ffff);
        $display("test abort status done");
        wr(8'h54, 32'h1);
        rd(8'h54, 32'h1);
        tryab(32'h0000_0100, sz_w, ty_r, 1, 1, 2);
        tryab(32'h0010_0000, sz_w, ty_r, 0, 1, 2);
        acc(32'h2000_0000, sz_w, ty_w, 0, 0, t_ext);
        for (i = 0; i < 16; i = i + 1) wr(8'h10 + 4 * i[7:0], 32'h0000_00c3);
        rd(8'h4c, 32'h0000_00c3);
        acc(32'h0, sz_w, ty_w, 1, 0, t_rom);
        wr(8'h14, 32'h0000_00c2);
        acc(32'h0020_0000, sz_w, ty_r, 1, 0, t_sram);
        tryab(32'h0020_0004, sz_w, ty_w, 1, 0, 2);
        acc(32'h0020_0004, sz_w, ty_w, 1, 1, t_sram);
        wr(8'h18, 32'h0000_0c00);
        tryab(32'h0000_0c04, sz_w, ty_r, 1, 1, 2);
        acc(32'h0000_1000, sz_w, ty_r, 1, 1, t_rom);
        acc(32'h0000_0bfc, sz_w, ty_r, 1, 1, t_rom);
        tryab(32'hffff_f000, sz_w, ty_r, 1, 1, 2);
        wr(8'h50, 32'h1);
        tryab(32'hffff_f004, sz_w, ty_r, 1, 0, 2);
        acc(32'hffff_f004, sz_w, ty_w, 0, 1, t_per);
        wr(8'h54, 32'h0);
        acc(32'h0010_0000, sz_w, ty_r, 1, 0, t_flash);
        $display("test protection done");
        repeat (4) @(posedge clk_sys_i);
        check(q_acc.size(), 0);
        check(q_rd.size(), 0);
        check(cpu_abts, n_cpu);
        wrap_up;
    end
endmodule
